// file: src/deac_cfg.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 40 MHz core clock, AXI4-Lite byte addresses
// Notes: Definitions only
`ifndef DEAC_CFG_SVH
`define DEAC_CFG_SVH

// ==========================================
// Register offsets
`define DEAC_OFF_CTRL 8'h00
`define DEAC_OFF_UNLOCK 8'h04
`define DEAC_OFF_ADDR 8'h08
`define DEAC_OFF_DATA 8'h0C
`define DEAC_OFF_STATUS 8'h10

// ==========================================
// Control register fields
`define DEAC_BIT_RD 0
`define DEAC_BIT_WR 1
`define DEAC_BIT_WENA 2
`define DEAC_BIT_WERR 3
`define DEAC_BIT_CSEL 6
`define DEAC_BIT_PMEM 7
// Status register fields
`define DEAC_BIT_DONE 0

// ==========================================
// Reset values and keys
`define DEAC_RST_BYTE 8'h00
`define DEAC_KEY_FIRST 8'h55
`define DEAC_KEY_SECOND 8'hAA
`define DEAC_RESP_OKAY 2'h0
`define DEAC_RESP_SLVERR 2'h2

// ==========================================
// Timing
`define DEAC_CLK_NS 25
`define DEAC_T_WRITE_NS 4000000
`define DEAC_T_PWRT_NS 65600
`define DEAC_WRITE_CYCLES ((`DEAC_T_WRITE_NS + `DEAC_CLK_NS - 1) / `DEAC_CLK_NS)
`define DEAC_PWRT_CYCLES ((`DEAC_T_PWRT_NS + `DEAC_CLK_NS - 1) / `DEAC_CLK_NS)

`endif

// file: src/deac_mem.sv
// Purpose: 256 x 8 data EEPROM array model
// Assumes: One write port, one read port, same clock
// Notes: Read data come out of a register
`timescale 1ns/1ps
`default_nettype none

module deac_mem (
  input wire logic aclk,
  input wire logic we,
  input wire logic re,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);

  // ==========================================
  // Array
  logic [7:0] mem [0:255];

  always_ff @(posedge aclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    if (re) begin
      rdata <= mem[addr];
    end
  end

endmodule
`default_nettype wire

// file: src/deac_pkg.sv
// Purpose: Types of the data EEPROM access controller
// Assumes: Constants come from deac_cfg.svh
// Notes: Whole module state is one packed struct
package deac_pkg;

  // ==========================================
  // Unlock tracker
  typedef enum logic [2:0] {
    DEAC_UL_IDLE = 3'b001,
    DEAC_UL_KEY1 = 3'b010,
    DEAC_UL_KEY2 = 3'b100
  } deac_ul_t;

  // ==========================================
  // State of the top module
  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_full;
    logic [7:0] awaddr;
    logic w_full;
    logic [7:0] wdata;
    logic wstb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic pmem_sel;
    logic cfg_sel;
    logic wr_err;
    logic wr_ena;
    logic wr;
    logic rd;
    logic irq_flag;
    logic [7:0] addr;
    logic [7:0] data;
    deac_ul_t ul;
    logic [17:0] wcnt;
    logic [11:0] pwrt_cnt;
    logic pwrt_done;
  } deac_state_t;

endpackage

// file: src/deac_top.sv
// Purpose: Byte access to a data EEPROM over AXI4-Lite
// Assumes: 40 MHz aclk, synchronous active-low reset
// Notes: Write cycle time is a parameter; power-up hold-off is a fixed define
`include "deac_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module deac_top #(
  parameter int WRITE_CYCLES = `DEAC_WRITE_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ==========================================
  // Constants
  localparam logic [17:0] WRITE_LAST = 18'(WRITE_CYCLES - 1);
  localparam logic [11:0] PWRT_LAST = 12'(`DEAC_PWRT_CYCLES - 1);

  // ==========================================
  // State
  deac_pkg::deac_state_t s;
  deac_pkg::deac_state_t next_s;

  logic do_wr;
  logic wr_done;
  logic mem_re;
  logic [7:0] mem_rdata;
  logic [7:0] wb;
  logic [7:0] rd_byte;
  logic rd_hit;

  // ==========================================
  // Functions
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == `DEAC_OFF_CTRL) || (a == `DEAC_OFF_UNLOCK) ||
                (a == `DEAC_OFF_ADDR) || (a == `DEAC_OFF_DATA) ||
                (a == `DEAC_OFF_STATUS);
  endfunction

  function automatic logic [7:0] ctrl_byte(input deac_pkg::deac_state_t st);
    ctrl_byte = `DEAC_RST_BYTE;
    ctrl_byte[`DEAC_BIT_PMEM] = st.pmem_sel;
    ctrl_byte[`DEAC_BIT_CSEL] = st.cfg_sel;
    ctrl_byte[`DEAC_BIT_WERR] = st.wr_err;
    ctrl_byte[`DEAC_BIT_WENA] = st.wr_ena;
    ctrl_byte[`DEAC_BIT_WR] = st.wr;
    ctrl_byte[`DEAC_BIT_RD] = st.rd;
  endfunction

  // ==========================================
  // Array
  deac_mem u_mem (
    .aclk(aclk),
    .we(wr_done),
    .re(mem_re),
    .addr(s.addr),
    .wdata(s.data),
    .rdata(mem_rdata)
  );

  // ==========================================
  // Read mux
  always_comb begin
    rd_hit = is_mapped(s_axi_araddr);
    rd_byte = `DEAC_RST_BYTE;
    unique case (s_axi_araddr)
      `DEAC_OFF_CTRL: begin
        rd_byte = ctrl_byte(s);
      end
      `DEAC_OFF_ADDR: begin
        rd_byte = s.addr;
      end
      `DEAC_OFF_DATA: begin
        rd_byte = s.data;
      end
      `DEAC_OFF_STATUS: begin
        rd_byte[`DEAC_BIT_DONE] = s.irq_flag;
      end
      default: begin
        // Unlock register is write-only, reads zero
        rd_byte = `DEAC_RST_BYTE;
      end
    endcase
  end

  // ==========================================
  // Next state
  always_comb begin
    next_s = s;
    do_wr = s.aw_full && s.w_full && !s.bvalid;
    wb = s.wdata;
    wr_done = s.wr && (s.wcnt == 18'h0_0000);
    mem_re = 1'b0;

    // Address and data channels, either order
    if (s_axi_awvalid && s.awready) begin
      next_s.aw_full = 1'b1;
      next_s.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wready) begin
      next_s.w_full = 1'b1;
      next_s.wdata = s_axi_wdata[7:0];
      next_s.wstb = s_axi_wstrb[0];
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end

    // Read channel
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s.arready) begin
      next_s.rvalid = 1'b1;
      next_s.rdata = {24'h00_0000, rd_byte};
      next_s.rresp = rd_hit ? `DEAC_RESP_OKAY : `DEAC_RESP_SLVERR;
    end

    if (s.rd) begin
      next_s.rd = 1'b0;
      // byte lands the cycle after the start
      next_s.data = mem_rdata;
    end

    // Register write
    if (do_wr) begin
      next_s.aw_full = 1'b0;
      next_s.w_full = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = is_mapped(s.awaddr) ? `DEAC_RESP_OKAY : `DEAC_RESP_SLVERR;
      if (s.awaddr != `DEAC_OFF_UNLOCK) begin
        next_s.ul = deac_pkg::DEAC_UL_IDLE;
      end
      // Lane 0 only; other lanes carry nothing here
      if (s.wstb && is_mapped(s.awaddr)) begin
        unique case (s.awaddr)
          `DEAC_OFF_UNLOCK: begin
            unique case (s.ul)
              deac_pkg::DEAC_UL_IDLE: begin
                next_s.ul = (wb == `DEAC_KEY_FIRST) ? deac_pkg::DEAC_UL_KEY1
                                                    : deac_pkg::DEAC_UL_IDLE;
              end
              deac_pkg::DEAC_UL_KEY1: begin
                next_s.ul = (wb == `DEAC_KEY_SECOND) ? deac_pkg::DEAC_UL_KEY2
                          : (wb == `DEAC_KEY_FIRST) ? deac_pkg::DEAC_UL_KEY1
                          : deac_pkg::DEAC_UL_IDLE;
              end
              deac_pkg::DEAC_UL_KEY2: begin
                next_s.ul = (wb == `DEAC_KEY_FIRST) ? deac_pkg::DEAC_UL_KEY1
                                                    : deac_pkg::DEAC_UL_IDLE;
              end
            endcase
          end
          `DEAC_OFF_CTRL: begin
            if (!s.wr) begin
              next_s.pmem_sel = wb[`DEAC_BIT_PMEM];
              next_s.cfg_sel = wb[`DEAC_BIT_CSEL];
              next_s.wr_ena = wb[`DEAC_BIT_WENA];
              // Error flag is clear-only from software
              if (!wb[`DEAC_BIT_WERR]) begin
                next_s.wr_err = 1'b0;
              end
              // refused with a select bit set
              if (wb[`DEAC_BIT_RD] && !wb[`DEAC_BIT_PMEM] && !wb[`DEAC_BIT_CSEL]) begin
                next_s.rd = 1'b1;
                mem_re = 1'b1;
              end
              // uses write-enable held before this write
              if (wb[`DEAC_BIT_WR] && s.wr_ena && s.ul == deac_pkg::DEAC_UL_KEY2 &&
                  !wb[`DEAC_BIT_PMEM] && !wb[`DEAC_BIT_CSEL]) begin
                if (s.pwrt_done) begin
                  next_s.wr = 1'b1;
                  next_s.wcnt = WRITE_LAST;
                end else begin
                  next_s.wr_err = 1'b1;
                  next_s.pmem_sel = s.pmem_sel;
                  next_s.cfg_sel = s.cfg_sel;
                end
              end
            end
          end
          `DEAC_OFF_ADDR: begin
            if (!s.wr) begin
              next_s.addr = wb;
            end
          end
          `DEAC_OFF_DATA: begin
            if (!s.wr) begin
              next_s.data = wb;
            end
          end
          `DEAC_OFF_STATUS: begin
            // Writing zero clears the flag
            if (!wb[`DEAC_BIT_DONE]) begin
              next_s.irq_flag = 1'b0;
            end
          end
          default: begin
            next_s.ul = deac_pkg::DEAC_UL_IDLE;
          end
        endcase
      end
    end

    // Write timer; after bus updates so a set beats a clear
    if (s.wr) begin
      if (wr_done) begin
        next_s.wr = 1'b0;
        next_s.irq_flag = 1'b1;
      end else begin
        next_s.wcnt = s.wcnt - 18'h0_0001;
      end
    end

    if (!s.pwrt_done) begin
      if (s.pwrt_cnt == PWRT_LAST) begin
        next_s.pwrt_done = 1'b1;
      end else begin
        next_s.pwrt_cnt = s.pwrt_cnt + 12'h001;
      end
    end

    // Ready flags registered so outputs come from flops
    next_s.awready = !next_s.aw_full && !next_s.bvalid;
    next_s.wready = !next_s.w_full && !next_s.bvalid;
    next_s.arready = !next_s.rvalid;
  end

  // ==========================================
  // Registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.ul <= deac_pkg::DEAC_UL_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================
  // Outputs
  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;

endmodule
`default_nettype wire

// file: verification/deac_checker.sv
// Purpose: Bus-side checks of the EEPROM access block
// Assumes: Bound to deac_top, one clock domain
// Notes: Sees AXI ports only; last read address kept locally
`include "deac_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module deac_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic [7:0] ra;
  logic bad_ra;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================
  // Address of the read in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ra <= 8'h00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      ra <= s_axi_araddr;
    end
  end
  assign bad_ra = (ra > `DEAC_OFF_STATUS) || (ra[1:0] != 2'b00);
  // ==========================================
  // Properties
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("read answer late");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer timing");
  unmapped_rd_a: assert property (s_axi_rvalid && bad_ra |->
    s_axi_rresp == `DEAC_RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read answer");
  unlock_rd_a: assert property (s_axi_rvalid && ra == `DEAC_OFF_UNLOCK |->
    s_axi_rdata == 32'h0000_0000) else $error("unlock register readable");
  status_rsvd_a: assert property (s_axi_rvalid && ra == `DEAC_OFF_STATUS |->
    s_axi_rdata[31:1] == 31'h0000_0000) else $error("status spare bits set");
endmodule

bind deac_top deac_checker i_deac_checker (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire

// file: verification/test_deac_top.sv
// Purpose: Self-checking bench of the EEPROM access block
// Assumes: Write cycle shortened to 60 clocks
// Notes: Handshakes sampled at the falling edge to avoid races
`include "deac_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module test_deac_top;
  localparam logic [7:0] A_CT = `DEAC_OFF_CTRL;
  localparam logic [7:0] A_UL = `DEAC_OFF_UNLOCK;
  localparam logic [7:0] A_AD = `DEAC_OFF_ADDR;
  localparam logic [7:0] A_DT = `DEAC_OFF_DATA;
  localparam logic [7:0] A_ST = `DEAC_OFF_STATUS;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, last_rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  int error_cnt, n_checks;

  deac_top #(.WRITE_CYCLES(60)) i_deac_top (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // ==========================================
  // Bus and compare tasks
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("BAD %s exp %h got %h", what, e, g);
      error_cnt++;
    end
  endtask
  task automatic tick(inout int n);
    @(posedge aclk);
    n++;
    if (n > 200) begin
      $display("BAD wait exp done got timeout");
      error_cnt++;
      close_out();
    end
  endtask
  function automatic logic [31:0] resp_of(input logic [7:0] a);
    return (a > A_ST || a[1:0] != 2'b00) ? 32'h0000_0002 : 32'h0000_0000;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic pa, pw, ta, tw, bv;
    logic [1:0] r;
    int n;
    pa = 1'b1;
    pw = 1'b1;
    bv = 1'b0;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h00_0000, d};
    wstrb <= 4'h1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (pa || pw || !bv) begin
      @(negedge aclk);
      ta = awready;
      tw = wready;
      bv = bvalid;
      r = bresp;
      tick(n);
      pa = pa && !ta;
      pw = pw && !tw;
      awvalid <= pa;
      wvalid <= pw;
    end
    bready <= 1'b0;
    chk("bresp", resp_of(a), {30'h0, r});
  endtask
  task automatic rdq(input logic [7:0] a);
    logic t;
    int n;
    t = 1'b0;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!t) begin
      @(negedge aclk);
      t = arready;
      tick(n);
    end
    arvalid <= 1'b0;
    t = 1'b0;
    while (!t) begin
      @(negedge aclk);
      t = rvalid;
      if (t) begin
        last_rd = rdata;
        chk("rresp", resp_of(a), {30'h0, rresp});
      end
      tick(n);
    end
    rready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rdq(a);
    chk($sformatf("reg %h", a), {24'h00_0000, e}, last_rd);
  endtask
  task automatic unlock;
    wr(A_UL, `DEAC_KEY_FIRST);
    wr(A_UL, `DEAC_KEY_SECOND);
  endtask

  // ==========================================
  // Scenarios
  task automatic t_pwrt;
    for (int i = 0; i < 6; i++) rd(8'(i * 4), 8'h00);
    wr(8'h14, 8'h01);
    wr(A_CT, 8'h04);
    unlock();
    wr(A_CT, 8'h06);
    rd(A_CT, 8'h0C);
    wr(A_CT, 8'h00);
    rd(A_CT, 8'h00);
    $display("power-up test done");
  endtask
  task automatic t_sel;
    wr(A_AD, 8'h10);
    wr(A_CT, 8'h81);
    rd(A_CT, 8'h80);
    wr(A_CT, 8'h41);
    rd(A_CT, 8'h40);
    wr(A_CT, 8'h00);
    $display("select test done");
  endtask
  task automatic t_guard;
    unlock();
    wr(A_CT, 8'h06);
    rd(A_CT, 8'h04);
    wr(A_UL, `DEAC_KEY_FIRST);
    wr(A_AD, 8'h3C);
    wr(A_UL, `DEAC_KEY_SECOND);
    wr(A_CT, 8'h06);
    rd(A_CT, 8'h04);
    wr(A_CT, 8'h00);
    unlock();
    wr(A_CT, 8'h02);
    rd(A_CT, 8'h00);
    rd(A_ST, 8'h00);
    wr(A_CT, 8'h00);
    $display("guard test done");
  endtask
  task automatic t_write;
    int n;
    n = 0;
    wr(A_DT, 8'hA5);
    wr(A_CT, 8'h04);
    unlock();
    wr(A_CT, 8'h06);
    rd(A_CT, 8'h06);
    wr(A_AD, 8'h11);
    wr(A_DT, 8'h22);
    wr(A_CT, 8'h00);
    rd(A_CT, 8'h06);
    rd(A_AD, 8'h3C);
    rd(A_DT, 8'hA5);
    do begin
      rdq(A_CT);
      tick(n);
    end while (last_rd[1] !== 1'b0);
    rd(A_CT, 8'h04);
    rd(A_ST, 8'h01);
    rd(A_ST, 8'h01);
    wr(A_ST, 8'h00);
    rd(A_ST, 8'h00);
    $display("write test done");
  endtask
  task automatic t_read;
    wr(A_DT, 8'h00);
    rd(A_DT, 8'h00);
    wr(A_CT, 8'h05);
    rd(A_DT, 8'hA5);
    rd(A_CT, 8'h04);
    rd(A_DT, 8'hA5);
    $display("read test done");
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wstrb, wdata} = 52'h0;
    error_cnt = 0;
    n_checks = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_pwrt();
    // Power-up hold-off cannot be shortened
    repeat (2624) @(posedge aclk);
    t_sel();
    t_guard();
    t_write();
    t_read();
    close_out();
  end
endmodule
`default_nettype wire
